// ---- edge_sync.sv ----
// Two-flop synchroniser with rising edge pulse
`timescale 1ns/1ps
module edge_sync (
	input  wire logic core_clk, // block clock
	input  wire logic rstn,     // synchronous reset, active low
	input  wire logic ce,       // clock enable
	input  wire logic async_in, // level from another domain
	output logic      rise      // one-cycle pulse on rising edge
);
	logic stage1;
	logic stage2;
	logic stage3;

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			stage1 <= 1'b0;
			stage2 <= 1'b0;
			stage3 <= 1'b0;
			rise   <= 1'b0;
		end else if (ce) begin
			stage1 <= async_in;
			stage2 <= stage1;
			stage3 <= stage2;
			rise   <= stage2 & ~stage3;
		end
	end
endmodule // edge_sync

// ---- lux_conv_ctrl.sv ----
// Conversion control and result registers of the light sensor
`timescale 1ns/1ps
module lux_conv_ctrl
	import lux_pkg::*;
(
	input  wire logic       core_clk,   // 40 MHz block clock
	input  wire logic       rstn,       // synchronous reset, active low
	input  wire logic       ce,         // clock enable, freezes state when low
	input  wire logic       osc_clk,    // internal oscillator, sampled
	input  wire logic       photo_pulse,// light-to-frequency pulses, sampled
	input  wire logic       wr_en,      // register write strobe
	input  wire logic       rd_en,      // register read strobe
	input  wire logic [7:0] addr,       // register address
	input  wire logic [7:0] wdata,      // write data
	output logic      [7:0] rdata,      // read data, valid after rd_en
	output logic      [1:0] full_scale_span, // span code to analog front end
	output logic            infrared_sel,    // 1 selects infrared sensing
	output logic            powered,         // front end powered
	output logic            conv_done        // pulse at each conversion end
);
	logic [7:0]          cmd;
	logic [15:0]         result;
	logic [15:0]         last_adc;
	logic [15:0]         last_timer;
	logic [16:0]         osc_count;
	logic [15:0]         adc_count;
	logic                osc_rise;
	logic                photo_rise;
	logic                active;
	conv_state_t         state;
	logic [2:0]          code;
	logic [16:0]         target;
	logic                cmd_write;
	logic                sync_write;
	logic                int_end;
	logic                ext_end;

	edge_sync osc_sync (
		.core_clk (core_clk),
		.rstn     (rstn),
		.ce       (ce),
		.async_in (osc_clk),
		.rise     (osc_rise)
	);

	edge_sync photo_sync (
		.core_clk (core_clk),
		.rstn     (rstn),
		.ce       (ce),
		.async_in (photo_pulse),
		.rise     (photo_rise)
	);

	assign code      = cmd[timing_select_bit:resolution_lo_bit];
	assign cmd_write = wr_en && addr == cmd_addr;
	assign sync_write = wr_en && addr[sync_addr_bit];

	always_comb begin
		case (cmd[resolution_hi_bit:resolution_lo_bit])
			2'b00:   target = cycles_res16;
			2'b01:   target = cycles_res12;
			2'b10:   target = cycles_res8;
			default: target = cycles_res4;
		endcase
	end

	assign int_end = state == conv_int && osc_rise && osc_count + 17'h00001 == target;
	assign ext_end = state == conv_ext && sync_write;

	// Command register, also arms a measurement
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			cmd    <= cmd_reset;
			active <= 1'b0;
		end else if (ce) begin
			if (cmd_write) begin
				cmd    <= wdata;
				active <= wdata[enable_bit];
			end else if ((int_end || ext_end) && !cmd[continuous_bit]) begin
				active <= 1'b0;
			end
		end
	end

	// Conversion sequencing
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			state <= conv_idle;
		end else if (ce) begin
			if (cmd_write || !active) begin
				state <= conv_idle;
			end else begin
				case (state)
					conv_idle: begin
						if (!code[2])
							state <= conv_int;
						else if (code == code_ext_adc || code == code_ext_timer)
							state <= conv_wait;
					end
					conv_wait: if (sync_write) state <= conv_ext;
					conv_int:  state <= conv_int;
					conv_ext:  state <= conv_ext;
					default:   state <= conv_idle;
				endcase
			end
		end
	end

	// Oscillator and photo counters; restart at each conversion boundary
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			osc_count <= 17'h00000;
			adc_count <= 16'h0000;
		end else if (ce) begin
			if (int_end || ext_end || (state != conv_int && state != conv_ext)) begin
				osc_count <= 17'h00000;
				adc_count <= 16'h0000;
			end else begin
				if (osc_rise && osc_count != 17'h0ffff)
					osc_count <= osc_count + 17'h00001;
				if (photo_rise && adc_count != 16'hffff)
					adc_count <= adc_count + 16'h0001;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			result     <= result_reset;
			last_adc   <= result_reset;
			last_timer <= result_reset;
			conv_done  <= 1'b0;
		end else if (ce) begin
			conv_done <= int_end || ext_end;
			if (int_end || ext_end) begin
				last_adc   <= adc_count;
				last_timer <= osc_count[15:0];
				result <= (code == code_ext_timer) ? osc_count[15:0] : adc_count;
			end else if (cmd_write && wdata[timing_select_bit:resolution_lo_bit] == code_ext_adc) begin
				result <= last_adc;
			end else if (cmd_write && wdata[timing_select_bit:resolution_lo_bit] == code_ext_timer) begin
				result <= last_timer;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			rdata <= 8'h00;
		end else if (ce && rd_en) begin
			case (addr)
				cmd_addr:         rdata <= cmd;
				result_low_addr:  rdata <= result[7:0];
				result_high_addr: rdata <= result[15:8];
				default:          rdata <= 8'h00;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			full_scale_span <= 2'b00;
			infrared_sel    <= 1'b0;
			powered         <= 1'b0;
		end else if (ce) begin
			full_scale_span <= cmd[span_select_hi:span_select_lo];
			infrared_sel    <= cmd[infrared_bit];
			powered         <= active;
		end
	end
endmodule // lux_conv_ctrl

// ---- lux_conv_ctrl_bench.sv ----
// Self-checking bench of the conversion control block
`timescale 1ns/1ps
module lux_conv_ctrl_bench;
	import lux_pkg::*;
	logic	core_clk = 0, rstn = 0, osc_clk = 0, photo_pulse = 0, ce = 1;
	logic	wr_en, rd_en, infrared_sel, powered, conv_done;
	logic [7:0]	addr, wdata, rdata, lo, hi;
	logic [1:0]	full_scale_span;
	int	failures = 0, checks_done = 0, dones = 0, seen;
	// Rows: command, span, infrared, powered
	logic [11:0]	rows [6] = '{12'h801, 12'h815, 12'h829, 12'h83d, 12'ha03, 12'h000};
	always #12.5 core_clk = ~core_clk;
	always @(posedge core_clk) if (conv_done === 1'b1) dones <= dones + 1;
	lux_conv_ctrl uut (.ce, .core_clk, .rstn, .osc_clk, .photo_pulse, .wr_en, .rd_en,
		.addr, .wdata, .rdata, .full_scale_span, .infrared_sel, .powered, .conv_done);
	lux_host_model host (.core_clk, .rdata, .wr_en, .rd_en, .addr, .wdata);
	task automatic chk(input string n, input logic [15:0] e, g);
		checks_done++;
		if (g !== e) begin
			failures++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask
	task automatic result_is(input logic [15:0] e);
		host.rd(result_low_addr, lo);
		host.rd(result_high_addr, hi);
		chk("result", e, {hi, lo});
	endtask
	// Oscillator or light pulses, 200 ns period, kept edge aligned
	task automatic pulses(input int n, input bit osc);
		repeat (n) begin
			if (osc) osc_clk = 1; else photo_pulse = 1;
			#100 {osc_clk, photo_pulse} = 2'b00;
			#100;
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge core_clk);
		#2 rstn = 1;
		result_is(16'h0000);
		foreach (rows[i]) begin
			host.wr(cmd_addr, rows[i][11:4]);
			host.rd(cmd_addr, lo);
			chk("command", rows[i][11:4], lo);
			chk("span", rows[i][3:2], full_scale_span);
			chk("infrared", rows[i][1], infrared_sel);
			chk("powered", rows[i][0], powered);
		end
		host.wr(cmd_addr, 8'h8c);
		pulses(5, 0);
		host.wr(8'h80, 8'h00);
		pulses(15, 1);
		#400 chk("early end", 0, dones);
		pulses(1, 1);
		#400 chk("done count", 1, dones);
		chk("single shot", 0, powered);
		result_is(16'h0005);
		host.wr(cmd_addr, 8'hd0);
		host.wr(8'h80, 8'h00);
		pulses(7, 0);
		pulses(9, 1);
		// Short sync spacing keeps the counter far from overflow
		#400 host.wr(8'h80, 8'h00);
		#400 result_is(16'h0007);
		host.wr(cmd_addr, 8'hd4);
		result_is(16'h0009);
		host.wr(8'h80, 8'h00);
		pulses(4, 0);
		pulses(3, 1);
		#400 host.wr(8'h80, 8'h00);
		#400 result_is(16'h0003);
		host.wr(cmd_addr, 8'hd0);
		result_is(16'h0004);
		host.wr(cmd_addr, 8'hd8);
		seen = dones;
		host.wr(8'h80, 8'h00);
		pulses(2, 0);
		pulses(2, 1);
		#400 host.wr(8'h80, 8'h00);
		#400 result_is(16'h0004);
		chk("no conversion", seen, dones);
		// Clock enable low must freeze the command register
		ce = 0;
		host.wr(cmd_addr, 8'hc3);
		ce = 1;
		host.rd(cmd_addr, lo);
		chk("frozen command", 8'hd8, lo);
		host.rd(8'h03, lo);
		chk("unmapped", 0, lo);
		host.wr(cmd_addr, 8'hc3);
		// Second reset in mid-run, with a live command
		@(posedge core_clk) #2 rstn = 0;
		repeat (4) @(posedge core_clk);
		#2 rstn = 1;
		chk("reset span", 0, full_scale_span);
		chk("reset powered", 0, powered);
		result_is(16'h0000);
		host.rd(cmd_addr, lo);
		chk("reset command", 0, lo);
		tally_and_finish;
	end
	initial begin
		#1000000;
		failures++;
		tally_and_finish;
	end
endmodule // lux_conv_ctrl_bench

// ---- lux_conv_ctrl_sva.sv ----
// Port assertions of the conversion control block
`timescale 1ns/1ps
module lux_conv_ctrl_sva
	import lux_pkg::*;
(
	input wire logic       core_clk,        // block clock
	input wire logic       rstn,            // synchronous reset, active low
	input wire logic       ce,              // clock enable
	input wire logic       osc_clk,         // oscillator level
	input wire logic       photo_pulse,     // light pulses
	input wire logic       wr_en,           // write strobe
	input wire logic       rd_en,           // read strobe
	input wire logic [7:0] addr,            // register address
	input wire logic [7:0] wdata,           // write data
	input wire logic [7:0] rdata,           // read data
	input wire logic [1:0] full_scale_span, // span code
	input wire logic       infrared_sel,    // sensing select
	input wire logic       powered,         // front end powered
	input wire logic       conv_done        // conversion end pulse
);
	wire logic cmd_wr = ce && wr_en && addr == cmd_addr;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	// Front-end outputs trail the command register by one more flop
	property p_span; cmd_wr |=> ##1 full_scale_span == $past(wdata[1:0], 2); endproperty
	a_span: assert property (p_span) else $error("span wrong");
	property p_hold; !cmd_wr |=> ##1 $stable(full_scale_span); endproperty
	a_hold: assert property (p_hold) else $error("span moved");
	property p_ir; cmd_wr |=> ##1 infrared_sel == $past(wdata[infrared_bit], 2); endproperty
	a_ir: assert property (p_ir) else $error("sensing wrong");
	property p_off; cmd_wr && !wdata[enable_bit] |=> ##1 !powered; endproperty
	a_off: assert property (p_off) else $error("not down");
	property p_on;
		cmd_wr && wdata[enable_bit] && !wdata[timing_select_bit] |=> ##[0:1] powered;
	endproperty
	a_on: assert property (p_on) else $error("not up");
	property p_pulse; conv_done |=> !conv_done; endproperty
	a_pulse: assert property (p_pulse) else $error("done too long");
	property p_idle; !powered && !$past(powered) && !$past(powered, 2) |-> !conv_done; endproperty
	a_idle: assert property (p_idle) else $error("done while down");
	property p_unmap; ce && rd_en && addr == 8'h03 |=> rdata == 8'h00; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped data");
	c_done: cover property (conv_done);
	c_sync: cover property (ce && wr_en && addr[sync_addr_bit]);
	c_read: cover property (rd_en && addr == result_high_addr);
endmodule // lux_conv_ctrl_sva
bind lux_conv_ctrl lux_conv_ctrl_sva chk (.core_clk, .rstn, .ce, .osc_clk, .photo_pulse,
	.wr_en, .rd_en, .addr, .wdata, .rdata, .full_scale_span, .infrared_sel, .powered, .conv_done);

// ---- lux_host_model.sv ----
// Register master model on the host side of the block
`timescale 1ns/1ps
module lux_host_model (
	input wire logic	core_clk,	// clock
	input wire logic [7:0]	rdata,	// read data
	output logic	wr_en = 0,	// write strobe
	output logic	rd_en = 0,	// read strobe
	output logic [7:0]	addr = 0,	// address
	output logic [7:0]	wdata = 0	// write data
);
	task automatic wr(input logic [7:0] a, d);
		@(posedge core_clk) #2 {wr_en, addr, wdata} = {1'b1, a, d};
		@(posedge core_clk) #2 wr_en = 0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk) #2 {rd_en, addr} = {1'b1, a};
		@(posedge core_clk) #2 rd_en = 0;
		d = rdata;
	endtask
endmodule // lux_host_model

// ---- lux_pkg.sv ----
// Constants for the light sensor conversion control block
package lux_pkg;
	localparam logic [7:0] cmd_addr         = 8'h00;
	localparam logic [7:0] result_low_addr  = 8'h01;
	localparam logic [7:0] result_high_addr = 8'h02;
	localparam logic [7:0] cmd_reset        = 8'h00;
	localparam logic [15:0] result_reset    = 16'h0000;
	localparam int sync_addr_bit   = 7;
	localparam int enable_bit      = 7;
	localparam int continuous_bit  = 6;
	localparam int infrared_bit    = 5;
	localparam int timing_select_bit = 4;
	localparam int resolution_hi_bit = 3;
	localparam int resolution_lo_bit = 2;
	localparam int span_select_hi  = 1;
	localparam int span_select_lo  = 0;
	localparam int count_width     = 16;
	// Integration lengths in oscillator cycles for resolution codes 0..3
	localparam logic [16:0] cycles_res16 = 17'h10000;
	localparam logic [16:0] cycles_res12 = 17'h01000;
	localparam logic [16:0] cycles_res8  = 17'h00100;
	localparam logic [16:0] cycles_res4  = 17'h00010;
	// Timing codes, command bits 4:2
	localparam logic [2:0] code_ext_adc   = 3'h4;
	localparam logic [2:0] code_ext_timer = 3'h5;
	typedef enum logic [1:0] {
		conv_idle = 2'b00,
		conv_int  = 2'b01,
		conv_wait = 2'b10,
		conv_ext  = 2'b11
	} conv_state_t;
endpackage
